// [common/ctr_pkg.sv]
// Shared constants, types and decoders for the timer routing block.
// Assumes an APB master with 32-bit data and one clock for everything.
`default_nettype none
package ctr_pkg;

    // ========================================================
    // Sizes
    localparam int NUM_UNITS  = 5;
    localparam int ADDR_W     = 8;

    // ========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_TMR3CTL   = 8'h00;
    localparam logic [7:0] ADDR_CONFIG    = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_UNIT_BASE = 8'h10;
    localparam logic [7:0] UNIT_STRIDE    = 8'h10;
    localparam logic [7:0] OFS_CTL        = 8'h00;
    localparam logic [7:0] OFS_LOW        = 8'h04;
    localparam logic [7:0] OFS_HIGH       = 8'h08;

    // ========================================================
    // Field positions
    localparam int ROUTE_HI_BIT  = 6;
    localparam int ROUTE_LO_BIT  = 3;
    localparam int CTL_IMPL_W    = 6;
    localparam int STAT_SEC_POS  = 2;
    localparam int STAT_PWM_POS  = 7;
    localparam int UNIT_E2       = 1;

    // ========================================================
    // Values after reset
    localparam logic [7:0] TMR3CTL_RST = 8'h00;
    localparam logic       PINSEL_RST  = 1'b1;

    // ========================================================
    // Modes and encodings
    localparam logic [1:0] PWM_PREFIX  = 2'h3;
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] TB_CAP_A    = 4'h1;
    localparam logic [3:0] TB_PWM_A    = 4'h2;
    localparam logic [3:0] TB_CAP_B    = 4'h4;
    localparam logic [3:0] TB_PWM_B    = 4'h8;
    localparam logic [3:0] TB_NONE     = 4'h0;

    typedef enum logic [1:0] {
        ROUTE_ALL_FIRST  = 2'h0,
        ROUTE_E1_FIRST   = 2'h1,
        ROUTE_E12_FIRST  = 2'h2,
        ROUTE_ALL_SECOND = 2'h3
    } ctr_route_type;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'h1,
        PH_ANSWER = 2'h2
    } ctr_phase_type;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } ctr_apb_req_type;

    typedef struct packed {
        logic [15:0] capA;
        logic [15:0] capB;
        logic [7:0]  pwmA;
        logic [7:0]  pwmB;
    } ctr_timebase_type;

    // ========================================================
    // Decoders
    function automatic logic ctr_is_pwm(input logic [3:0] mode);
        return mode[3:2] == PWM_PREFIX;
    endfunction

    function automatic logic ctr_uses_second(input ctr_route_type r,
                                             input logic [2:0] unit);
        case (r)
            ROUTE_ALL_FIRST:  return 1'b0;
            ROUTE_E1_FIRST:   return unit != 3'h0;
            ROUTE_E12_FIRST:  return unit > 3'h1;
            ROUTE_ALL_SECOND: return 1'b1;
            default:          return 1'b0;
        endcase
    endfunction

endpackage
`default_nettype wire

// [rtl/ctr_route.sv]
// Time base selector for one capture/compare/PWM unit.
// Assumes the routing select and mode come from registered state.
`timescale 1ns/1ps
`default_nettype none
module ctr_route #(
    parameter logic [2:0] UNIT = 3'h0
) (
    // Selection
    input  wire ctr_pkg::ctr_route_type    route,
    input  wire logic [3:0]                mode,
    // Time bases
    input  wire ctr_pkg::ctr_timebase_type tb,
    // Result
    output logic [3:0]                     tbSel,
    output logic [15:0]                    tbValue,
    output logic                           second,
    output logic                           pwm
);

    // ========================================================
    // Class and pair selection
    always_comb begin
        pwm    = ctr_pkg::ctr_is_pwm(mode);
        second = ctr_pkg::ctr_uses_second(route, UNIT);
        if (mode == ctr_pkg::MODE_OFF) begin
            tbSel   = ctr_pkg::TB_NONE;
            tbValue = 16'h0000;
        end else if (pwm) begin
            // PWM work only on the PWM time bases
            tbSel   = second ? ctr_pkg::TB_PWM_B : ctr_pkg::TB_PWM_A;
            tbValue = second ? {8'h00, tb.pwmB} : {8'h00, tb.pwmA};
        end else begin
            // Capture and compare only on capture bases
            tbSel   = second ? ctr_pkg::TB_CAP_B : ctr_pkg::TB_CAP_A;
            tbValue = second ? tb.capB : tb.capA;
        end
    end

endmodule
`default_nettype wire

// [rtl/ctr_top.sv]
// Register file, time base routing and pin routing of the units.
// Assumes an APB master on ref_clk and timers owned by the neighbours.
//
// Contract
// - Each unit has a control register and a value split in two bytes.
// - Control, low and high value registers are all readable and writable.
// - Capture and compare use only the first or third timer.
// - PWM uses only the second or fourth timer.
// - Two routing bits in the capture_timebase_b control register pick the assignment.
// - One setting routes every unit to the first and second timers.
// - Select 01: only unit 1 on first pair, others on second pair.
// - Select 10: units 1 and 2 on first pair, others on second pair.
// - Select 11: every unit on third and fourth timers.
// - Units on one timer in one mode class share it as time base.
// - Pin select high, its default, puts unit 2 on port C bit 1.
// - Pin select low: port E bit 7, or B3/E7 by mode on large parts.
// - Unimplemented control bits, the top two among them, read as zero.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module ctr_top (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    // APB slave
    input  wire ctr_pkg::ctr_apb_req_type  apbReq,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // Time bases
    input  wire ctr_pkg::ctr_timebase_type timebase,
    // Unit registers and routing
    output logic [4:0][7:0]                unitControl,
    output logic [4:0][15:0]               unitValue,
    output logic [4:0][3:0]                unitTimebaseSel,
    output logic [4:0][15:0]               unitTimebaseValue,
    // Unit 2 pin routing
    input  wire logic                      largePackage,
    input  wire logic                      unit2DriveOut,
    input  wire logic                      unit2DriveEn,
    output logic                           unit2CaptureIn,
    input  wire logic                      portCBit1In,
    output logic                           portCBit1Out,
    output logic                           portCBit1Oe,
    input  wire logic                      portEBit7In,
    output logic                           portEBit7Out,
    output logic                           portEBit7Oe,
    input  wire logic                      portBBit3In,
    output logic                           portBBit3Out,
    output logic                           portBBit3Oe
);

    localparam int NU = ctr_pkg::NUM_UNITS;
    localparam int CW = ctr_pkg::CTL_IMPL_W;

    // ========================================================
    // State
    typedef struct packed {
        ctr_pkg::ctr_phase_type phase;
        logic [31:0]            rdata;
        logic                   err;
        logic [7:0]             tmr3Ctl;
        logic                   pinSel;
        logic [4:0][CW-1:0]     unitCtl;
        logic [4:0][7:0]        unitLow;
        logic [4:0][7:0]        unitHigh;
        logic [4:0][3:0]        tbSel;
        logic [4:0][15:0]       tbVal;
        logic                   capIn;
        logic                   c1Out;
        logic                   c1Oe;
        logic                   e7Out;
        logic                   e7Oe;
        logic                   b3Out;
        logic                   b3Oe;
    } ctr_state_type;

    localparam ctr_state_type ST_RST = '{
        phase:   ctr_pkg::PH_IDLE,
        tmr3Ctl: ctr_pkg::TMR3CTL_RST,
        pinSel:  ctr_pkg::PINSEL_RST,
        default: '0
    };

    ctr_state_type st_r;
    ctr_state_type st_nxt;

    // ========================================================
    // Address decode
    function automatic logic ctr_hit(input logic [7:0] a,
                                     input int unsigned u,
                                     input logic [7:0] ofs);
        logic [7:0] base;
        base = ctr_pkg::ADDR_UNIT_BASE + 8'(u * 16) + ofs;
        return a == base;
    endfunction

    // ========================================================
    // Routing per unit
    ctr_pkg::ctr_route_type route;
    logic [4:0][3:0]        routeSel;
    logic [4:0][15:0]       routeVal;
    logic [4:0]             routeSecond;
    logic [4:0]             routePwm;

    // Select comes from the two split bits, reset value 00
    assign route = ctr_pkg::ctr_route_type'(
        {st_r.tmr3Ctl[ctr_pkg::ROUTE_HI_BIT],
         st_r.tmr3Ctl[ctr_pkg::ROUTE_LO_BIT]});

    // Shared time bases are plain fan-out of one timer
    // Pair choice per select value
    generate
        for (genvar g = 0; g < NU; g++) begin : gUnit
            ctr_route #(
                .UNIT (3'(g))
            ) uRoute (
                .route   (route),
                .mode    (st_r.unitCtl[g][3:0]),
                .tb      (timebase),
                .tbSel   (routeSel[g]),
                .tbValue (routeVal[g]),
                .second  (routeSecond[g]),
                .pwm     (routePwm[g])
            );
        end
    endgenerate

    // ========================================================
    // Next state
    always_comb begin
        logic [7:0] a;
        logic       useC1;
        logic       useE7;
        a      = apbReq.paddr;
        useC1  = 1'b0;
        useE7  = 1'b0;
        st_nxt = st_r;

        // Bus read and write sides and phase
        case (st_r.phase)
            ctr_pkg::PH_IDLE: begin
                if (apbReq.psel && !apbReq.penable) begin
                    st_nxt.phase = ctr_pkg::PH_ANSWER;
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.err   = 1'b1;
                    if (a == ctr_pkg::ADDR_TMR3CTL) begin
                        st_nxt.rdata = {24'h000000, st_r.tmr3Ctl};
                        st_nxt.err   = 1'b0;
                    end
                    if (a == ctr_pkg::ADDR_CONFIG) begin
                        st_nxt.rdata = {31'h0, st_r.pinSel};
                        st_nxt.err   = 1'b0;
                    end
                    if (a == ctr_pkg::ADDR_STATUS) begin
                        st_nxt.rdata = {20'h00000, routePwm,
                                        routeSecond, route};
                        st_nxt.err   = 1'b0;
                    end
                    for (int u = 0; u < NU; u++) begin
                        if (ctr_hit(a, u, ctr_pkg::OFS_CTL)) begin
                            // Top bits read as zero
                            st_nxt.rdata = {26'h0, st_r.unitCtl[u]};
                            st_nxt.err   = 1'b0;
                        end
                        if (ctr_hit(a, u, ctr_pkg::OFS_LOW)) begin
                            st_nxt.rdata = {24'h0, st_r.unitLow[u]};
                            st_nxt.err   = 1'b0;
                        end
                        if (ctr_hit(a, u, ctr_pkg::OFS_HIGH)) begin
                            st_nxt.rdata = {24'h0, st_r.unitHigh[u]};
                            st_nxt.err   = 1'b0;
                        end
                    end
                end
            end
            ctr_pkg::PH_ANSWER: begin
                st_nxt.phase = ctr_pkg::PH_IDLE;
                if (apbReq.psel && apbReq.penable && apbReq.pwrite
                    && !st_r.err) begin
                    if (a == ctr_pkg::ADDR_TMR3CTL) begin
                        st_nxt.tmr3Ctl = apbReq.pwdata[7:0];
                    end
                    if (a == ctr_pkg::ADDR_CONFIG) begin
                        st_nxt.pinSel = apbReq.pwdata[0];
                    end
                    for (int u = 0; u < NU; u++) begin
                        if (ctr_hit(a, u, ctr_pkg::OFS_CTL)) begin
                            // Only implemented bits kept
                            st_nxt.unitCtl[u] = apbReq.pwdata[CW-1:0];
                        end
                        if (ctr_hit(a, u, ctr_pkg::OFS_LOW)) begin
                            st_nxt.unitLow[u] = apbReq.pwdata[7:0];
                        end
                        if (ctr_hit(a, u, ctr_pkg::OFS_HIGH)) begin
                            st_nxt.unitHigh[u] = apbReq.pwdata[7:0];
                        end
                    end
                end
            end
            default: begin
                st_nxt.phase = ctr_pkg::PH_IDLE;
            end
        endcase

        // Time base routing outputs
        st_nxt.tbSel = routeSel;
        st_nxt.tbVal = routeVal;

        // Unit 2 pin choice
        useC1 = st_r.pinSel;
        useE7 = !st_r.pinSel
                && (!largePackage || routePwm[ctr_pkg::UNIT_E2]);
        st_nxt.c1Oe  = useC1 && unit2DriveEn;
        st_nxt.c1Out = useC1 && unit2DriveOut;
        st_nxt.e7Oe  = useE7 && unit2DriveEn;
        st_nxt.e7Out = useE7 && unit2DriveOut;
        st_nxt.b3Oe  = !useC1 && !useE7 && unit2DriveEn;
        st_nxt.b3Out = !useC1 && !useE7 && unit2DriveOut;
        // Pin direction stays software's job
        if (useC1) begin
            st_nxt.capIn = portCBit1In;
        end else if (useE7) begin
            st_nxt.capIn = portEBit7In;
        end else begin
            st_nxt.capIn = portBBit3In;
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // Outputs
    assign pready  = st_r.phase == ctr_pkg::PH_ANSWER;
    assign prdata  = st_r.rdata;
    assign pslverr = pready && st_r.err;

    // Two-byte value per unit
    generate
        for (genvar g = 0; g < NU; g++) begin : gOut
            assign unitControl[g] = {2'b00, st_r.unitCtl[g]};
            assign unitValue[g]   = {st_r.unitHigh[g], st_r.unitLow[g]};
        end
    endgenerate

    assign unitTimebaseSel   = st_r.tbSel;
    assign unitTimebaseValue = st_r.tbVal;
    assign unit2CaptureIn    = st_r.capIn;
    assign portCBit1Out      = st_r.c1Out;
    assign portCBit1Oe       = st_r.c1Oe;
    assign portEBit7Out      = st_r.e7Out;
    assign portEBit7Oe       = st_r.e7Oe;
    assign portBBit3Out      = st_r.b3Out;
    assign portBBit3Oe       = st_r.b3Oe;

endmodule
`default_nettype wire

// [sim/ctr_top_assertions.sv]
// Port checker for the timer routing block.
// Assumes a bind to ctr_top and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctr_top_assertions (
    // Clock and reset
    input wire logic                      ref_clk,
    input wire logic                      reset_n,
    // Bus
    input wire ctr_pkg::ctr_apb_req_type  apbReq,
    input wire logic                      pready,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    // Units
    input wire ctr_pkg::ctr_timebase_type timebase,
    input wire logic [4:0][7:0]           unitControl,
    input wire logic [4:0][3:0]           unitTimebaseSel,
    input wire logic [4:0][15:0]          unitTimebaseValue,
    // Pins
    input wire logic                      unit2DriveOut,
    input wire logic                      unit2DriveEn,
    input wire logic                      portCBit1Out,
    input wire logic                      portCBit1Oe,
    input wire logic                      portEBit7Oe,
    input wire logic                      portBBit3Oe
);
    // ============================================================
    // Bus and pin checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_READY_AFTER_SETUP: assert property (
        apbReq.psel && !apbReq.penable |=> pready) else $error("no answer");
    AST_READY_ONE: assert property (
        pready |=> !pready) else $error("answer too long");
    AST_ERR_ZERO: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("bad error reply");
    AST_PIN_SINGLE: assert property (
        $onehot0({portCBit1Oe, portEBit7Oe, portBBit3Oe}))
        else $error("two pins driven");
    AST_PIN_C_FOLLOWS: assert property (
        portCBit1Oe |-> $past(unit2DriveEn)
        && portCBit1Out == $past(unit2DriveOut)) else $error("pin C wrong");
    // ============================================================
    // Per unit checks
    genvar u;
    for (u = 0; u < 5; u++) begin : g_unit
        AST_CTL_TOP_ZERO: assert property (
            unitControl[u][7:6] == 2'h0) else $error("top bits set");
        AST_CAP_CLASS: assert property (
            unitTimebaseSel[u] inside {4'h1, 4'h4}
            |-> $past(unitControl[u][3:2]) != 2'h3
            && $past(unitControl[u][3:0]) != 4'h0)
            else $error("capture on wrong timer");
        AST_PWM_CLASS: assert property (
            unitTimebaseSel[u] inside {4'h2, 4'h8}
            |-> $past(unitControl[u][3:2]) == 2'h3)
            else $error("pwm on wrong timer");
        AST_CAP_A_VALUE: assert property (
            unitTimebaseSel[u] == 4'h1 && $past(unitTimebaseSel[u]) == 4'h1
            |-> unitTimebaseValue[u] == $past(timebase.capA))
            else $error("first timer value wrong");
        AST_PWM_B_VALUE: assert property (
            unitTimebaseSel[u] == 4'h8 && $past(unitTimebaseSel[u]) == 4'h8
            |-> unitTimebaseValue[u] == {8'h00, $past(timebase.pwmB)})
            else $error("fourth timer value wrong");
    end
    cover property (pready && pslverr);
    cover property (unitTimebaseSel[4] == 4'h8);
    cover property (portBBit3Oe);
endmodule
bind ctr_top ctr_top_assertions chk_u (
    .ref_clk, .reset_n, .apbReq, .pready, .prdata, .pslverr, .timebase,
    .unitControl, .unitTimebaseSel, .unitTimebaseValue, .unit2DriveOut,
    .unit2DriveEn, .portCBit1Out, .portCBit1Oe, .portEBit7Oe, .portBBit3Oe
);
`default_nettype wire

// [sim/ctr_far_model.sv]
// Timers and pads on the far side of the routing block.
// Assumes one clock; an undriven pad follows the bench level.
`timescale 1ns/1ps
`default_nettype none
module ctr_far_model (
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    // Time bases
    output var ctr_pkg::ctr_timebase_type timebase,
    // Pads, order B3 E7 C1
    input  wire logic                     extLevel,
    input  wire logic [2:0]               padOut,
    input  wire logic [2:0]               padOe,
    output logic [2:0]                    padIn
);
    // ============================================================
    // Four timers running at once, steps 1, 3, 1 and 5
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timebase <= '0;
        end else begin
            timebase.capA <= timebase.capA + 16'h0001;
            timebase.capB <= timebase.capB + 16'h0003;
            timebase.pwmA <= timebase.pwmA + 8'h01;
            timebase.pwmB <= timebase.pwmB + 8'h05;
        end
    end
    // Driver wins, else the outside level
    assign padIn = (padOe & padOut) | (~padOe & {3{extLevel}});
endmodule
`default_nettype wire

// [sim/ccp_timer_routing_tb.sv]
// Self-checking bench for the timer routing block.
// Assumes ctr_top, its checker and the far-side model are compiled.
`timescale 1ns/1ps
`default_nettype none
module ccp_timer_routing_tb;
    // ============================================================
    // Signals
    logic                      ref_clk;
    logic                      reset_n;
    ctr_pkg::ctr_apb_req_type  apbReq;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    ctr_pkg::ctr_timebase_type timebase;
    logic [4:0][7:0]           unitControl;
    logic [4:0][15:0]          unitValue;
    logic [4:0][3:0]           unitTimebaseSel;
    logic                      largePackage;
    logic                      unit2DriveOut;
    logic                      unit2DriveEn;
    logic                      unit2CaptureIn;
    logic                      extLevel;
    logic [2:0]                padIn;
    logic [2:0]                padOut;
    logic [2:0]                padOe;
    logic [32:0]               expQ[$];
    int                        err_count;
    int                        cmp_count;
    int                        seed;

    ctr_top dut_u (
        .ref_clk, .reset_n, .apbReq, .pready, .prdata, .pslverr, .timebase,
        .unitControl, .unitValue, .unitTimebaseSel, .unitTimebaseValue(),
        .largePackage, .unit2DriveOut, .unit2DriveEn, .unit2CaptureIn,
        .portCBit1In(padIn[0]), .portCBit1Out(padOut[0]),
        .portCBit1Oe(padOe[0]), .portEBit7In(padIn[1]),
        .portEBit7Out(padOut[1]), .portEBit7Oe(padOe[1]),
        .portBBit3In(padIn[2]), .portBBit3Out(padOut[2]),
        .portBBit3Oe(padOe[2])
    );
    ctr_far_model far_u (
        .ref_clk, .reset_n, .timebase, .extLevel, .padOut, .padOe, .padIn
    );

    // ============================================================
    // Tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        apbReq <= '0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic [7:0] ua(input int u, input logic [7:0] o);
        return 8'(ctr_pkg::ADDR_UNIT_BASE + ctr_pkg::UNIT_STRIDE * u) + o;
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ============================================================
    // Clock, read monitor, watchdog
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (pready === 1'b1 && apbReq.pwrite === 1'b0 && expQ.size() > 0)
            check({pslverr, prdata}, expQ.pop_front());
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        finish_test();
    end

    // ============================================================
    // Scenarios
    initial begin
        int u, r, m, i;
        logic sec;
        logic [4:0] secs;
        logic [31:0] c, l, h;
        logic [3:0] md, pin;
        seed = 32'h92313A26;
        err_count = 0;
        cmp_count = 0;
        apbReq = '0;
        reset_n = 1'b0;
        largePackage = 1'b0;
        unit2DriveOut = 1'b0;
        unit2DriveEn = 1'b0;
        extLevel = 1'b0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        rd(ctr_pkg::ADDR_TMR3CTL, 33'h0);
        rd(ctr_pkg::ADDR_CONFIG, 33'h1);
        check(33'(unitTimebaseSel), 33'h0);
        $display("test reset done");
        for (u = 0; u < 5; u++) begin
            c = (u == 0) ? 32'hFFFFFFFF : $random(seed);
            l = $random(seed);
            h = $random(seed);
            wr(ua(u, ctr_pkg::OFS_CTL), c);
            wr(ua(u, ctr_pkg::OFS_LOW), l);
            wr(ua(u, ctr_pkg::OFS_HIGH), h);
            rd(ua(u, ctr_pkg::OFS_CTL), {27'h0, c[5:0]});
            rd(ua(u, ctr_pkg::OFS_LOW), {25'h0, l[7:0]});
            rd(ua(u, ctr_pkg::OFS_HIGH), {25'h0, h[7:0]});
            check(33'(unitValue[u]), {17'h0, h[7:0], l[7:0]});
        end
        rd(8'hFC, {1'b1, 32'h0});
        wr(8'hFC, 32'hFFFFFFFF);
        rd(ctr_pkg::ADDR_TMR3CTL, 33'h0);
        $display("test registers done");
        for (r = 0; r < 4; r++) begin
            wr(ctr_pkg::ADDR_TMR3CTL, {25'h0, r[1], 2'h0, r[0], 3'h0});
            for (m = 0; m < 3; m++) begin
                md = (m == 0) ? 4'h0 : (m == 1) ? 4'h4 : 4'hC;
                for (u = 0; u < 5; u++)
                    wr(ua(u, ctr_pkg::OFS_CTL), {28'h0, md});
                @(posedge ref_clk);
                for (u = 0; u < 5; u++) begin
                    sec = r == 3 || (r == 1 && u != 0) || (r == 2 && u > 1);
                    secs[u] = sec;
                    pin = (md == 4'h4) ? (sec ? 4'h4 : 4'h1) :
                          (md == 4'hC) ? (sec ? 4'h8 : 4'h2) : 4'h0;
                    check(33'(unitTimebaseSel[u]), 33'(pin));
                end
                if (md != 4'h0)
                    rd(ctr_pkg::ADDR_STATUS, {21'h0, {5{md == 4'hC}},
                       secs, r[1:0]});
            end
        end
        $display("test routing done");
        for (i = 0; i < 4; i++) begin
            wr(ctr_pkg::ADDR_CONFIG, {31'h0, i == 0});
            wr(ua(ctr_pkg::UNIT_E2, ctr_pkg::OFS_CTL),
               (i == 3) ? 32'hC : 32'h4);
            largePackage <= i > 1;
            pin = (i == 0) ? 4'h1 : (i == 2) ? 4'h4 : 4'h2;
            repeat (4) begin
                unit2DriveEn <= 1'($random(seed));
                unit2DriveOut <= 1'($random(seed));
                extLevel <= 1'($random(seed));
                repeat (3) @(posedge ref_clk);
                check({30'h0, padOe},
                      {30'h0, pin[2:0] & {3{unit2DriveEn}}});
                check({32'h0, unit2CaptureIn}, {32'h0, unit2DriveEn ?
                      unit2DriveOut : extLevel});
            end
        end
        $display("test pins done");
        finish_test();
    end
endmodule
`default_nettype wire
